// ==== core/strap_config_loader.sv ====
`default_nettype none
module strap_config_loader #(
    parameter int unsigned STRAP_WINDOW_CYC = strap_cfg_pkg::STRAP_WINDOW_CYC_DEF
) (
    input  wire logic               ref_clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               chip_rst_n_i,
    input  wire logic [5:0]         gpio_i,
    output logic      [5:0]         gpio_o,
    output logic      [5:0]         gpio_oe_o,
    input  wire logic               otp_programmed_i,
    output logic                    otp_rd_o,
    output logic      [7:0]         otp_addr_o,
    input  wire logic [7:0]         otp_data_i,
    input  wire logic               host_wr_i,
    input  wire logic               host_rd_i,
    input  wire logic [7:0]         host_addr_i,
    input  wire logic [7:0]         host_wdata_i,
    output logic                    host_ready_o,
    output logic                    host_rvalid_o,
    output logic      [7:0]         host_rdata_o,
    output strap_cfg_pkg::mclk_e    mclk_freq_o,
    output logic      [5:0]         strap_cfg_o,
    output logic      [7:0]         clk_out_enable_o,
    output logic      [3:0]         ref_diff_o,
    output logic      [7:0]         se_slew_fast_o,
    output logic                    cfg_running_o
);
    localparam logic [31:0] WIN_LAST = 32'(STRAP_WINDOW_CYC - 1);
    logic                          rst_n_sync;
    logic [5:0]                    gpio_sync;
    logic [7:0]                    mem_rdata;
    strap_cfg_pkg::ldr_state_e     state_reg, state_next;
    logic [7:0]                    cnt_reg, cnt_next;
    logic [31:0]                   win_reg, win_next;
    logic                          sweep_done_reg, sweep_done_next;
    logic                          pend_reg, pend_next;
    logic [7:0]                    pend_addr_reg, pend_addr_next;
    logic                          capture;
    logic [1:0]                    mclk_sel_reg, mclk_sel_next;
    strap_cfg_pkg::mclk_e          mclk_freq_reg, mclk_freq_next;
    logic [5:0]                    strap_reg, strap_next;
    logic                          test_strap_reg, test_strap_next;
    logic                          wr_en;
    logic [7:0]                    wr_addr;
    logic [7:0]                    wr_data;
    logic                          host_acc;
    logic                          host_wr_ok;
    logic [7:0]                    ref_type_reg, ref_type_next;
    logic [7:0]                    out_en_reg, out_en_next;
    logic [7:0]                    slew_reg, slew_next;
    logic [7:0]                    gpo_reg, gpo_next;
    logic [7:0]                    gpoe_reg, gpoe_next;
    logic                          rvalid_reg, rvalid_next;
    logic [7:0]                    rdata_reg, rdata_next;
    logic [7:0]                    clk_en_reg, clk_en_next;
    logic [5:0]                    gpio_out_reg, gpio_out_next;
    logic [5:0]                    gpio_oe_reg, gpio_oe_next;
    dual_ff_sync #(.WIDTH(1)) u_rst_sync (
        .clk_i   (ref_clk_i),
        .rst_i   (sys_rst_i),
        .async_i (chip_rst_n_i),
        .sync_o  (rst_n_sync)
    );
    dual_ff_sync #(.WIDTH(strap_cfg_pkg::GPIO_W)) u_gpio_sync (
        .clk_i   (ref_clk_i),
        .rst_i   (sys_rst_i),
        .async_i (gpio_i),
        .sync_o  (gpio_sync)
    );
    cfg_space_mem u_cfg (
        .clk_i     (ref_clk_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (wr_addr),
        .wr_data_i (wr_data),
        .rd_addr_i (host_addr_i),
        .rd_data_o (mem_rdata)
    );

    // Loader sequence: default sweep, image load, strap window, run
    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg;
        win_next        = win_reg;
        sweep_done_next = sweep_done_reg;
        pend_next       = 1'b0;
        pend_addr_next  = cnt_reg;
        capture         = 1'b0;
        case (state_reg)
            strap_cfg_pkg::ST_HOLD: begin
                cnt_next = (cnt_reg >= strap_cfg_pkg::CFG_LAST) ? 8'h00 : cnt_reg + 8'h01;
                sweep_done_next = sweep_done_reg | (cnt_reg >= strap_cfg_pkg::CFG_LAST);
                win_next = 32'h0;
                // Leaving waits for one full sweep so no byte is left unwritten
                if (rst_n_sync && sweep_done_reg) begin
                    capture    = 1'b1;
                    cnt_next   = 8'h00;
                    state_next = otp_programmed_i ? strap_cfg_pkg::ST_LOAD : strap_cfg_pkg::ST_STRAP;
                end
            end
            strap_cfg_pkg::ST_LOAD: begin
                pend_next = 1'b1;
                cnt_next  = cnt_reg + 8'h01;
                if (cnt_reg == strap_cfg_pkg::CFG_LAST) begin
                    state_next = strap_cfg_pkg::ST_STRAP;
                end
            end
            strap_cfg_pkg::ST_STRAP: begin
                if (win_reg == WIN_LAST) begin
                    state_next = strap_cfg_pkg::ST_RUN;
                end
            end
            strap_cfg_pkg::ST_RUN:  state_next = strap_cfg_pkg::ST_RUN;
            default:                state_next = strap_cfg_pkg::ST_HOLD;
        endcase
        // The window runs from release, image load time included
        if (state_reg != strap_cfg_pkg::ST_HOLD && win_reg != WIN_LAST) begin
            win_next = win_reg + 32'h1;
        end
        if (!rst_n_sync && state_reg != strap_cfg_pkg::ST_HOLD) begin
            state_next      = strap_cfg_pkg::ST_HOLD;
            sweep_done_next = 1'b0;
            pend_next       = 1'b0;
            // Restart the sweep at zero so an aborted load cannot skip low addresses
            cnt_next        = 8'h00;
        end
    end
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg      <= strap_cfg_pkg::ST_HOLD;
            cnt_reg        <= 8'h00;
            win_reg        <= 32'h0;
            sweep_done_reg <= 1'b0;
            pend_reg       <= 1'b0;
            pend_addr_reg  <= 8'h00;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            win_reg        <= win_next;
            sweep_done_reg <= sweep_done_next;
            pend_reg       <= pend_next;
            pend_addr_reg  <= pend_addr_next;
        end
    end

    // Straps are caught once, on the release of the reset pin
    always_comb begin
        mclk_sel_next   = mclk_sel_reg;
        mclk_freq_next  = mclk_freq_reg;
        strap_next      = strap_reg;
        test_strap_next = test_strap_reg;
        if (capture) begin
            mclk_sel_next   = gpio_sync[1:0];
            mclk_freq_next  = strap_cfg_pkg::mclk_decode(gpio_sync[1:0]);
            strap_next      = gpio_sync & strap_cfg_pkg::STRAP_MASK;
            test_strap_next = gpio_sync[strap_cfg_pkg::TEST_STRAP_BIT];
        end
    end
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mclk_sel_reg   <= 2'h0;
            mclk_freq_reg  <= strap_cfg_pkg::MCLK_RESERVED;
            strap_reg      <= 6'h00;
            test_strap_reg <= 1'b0;
        end else begin
            mclk_sel_reg   <= mclk_sel_next;
            mclk_freq_reg  <= mclk_freq_next;
            strap_reg      <= strap_next;
            test_strap_reg <= test_strap_next;
        end
    end

    // One write port for all three sources; a pending image byte outranks the host
    always_comb begin
        host_acc   = (state_reg == strap_cfg_pkg::ST_STRAP || state_reg == strap_cfg_pkg::ST_RUN) && !pend_reg;
        host_wr_ok = host_acc && host_wr_i && (32'(host_addr_i) < strap_cfg_pkg::CFG_DEPTH);
        wr_en      = 1'b0;
        wr_addr    = cnt_reg;
        wr_data    = strap_cfg_pkg::cfg_default(cnt_reg);
        if (state_reg == strap_cfg_pkg::ST_HOLD) begin
            wr_en = 1'b1;
        end else if (pend_reg) begin
            wr_en   = 1'b1;
            wr_addr = pend_addr_reg;
            wr_data = otp_data_i;
        end else if (host_wr_ok) begin
            wr_en   = 1'b1;
            wr_addr = host_addr_i;
            wr_data = host_wdata_i;
        end
        ref_type_next = ref_type_reg;
        out_en_next   = out_en_reg;
        slew_next     = slew_reg;
        gpo_next      = gpo_reg;
        gpoe_next     = gpoe_reg;
        if (state_reg == strap_cfg_pkg::ST_HOLD) begin
            ref_type_next = strap_cfg_pkg::REF_TYPE_RESET;
            out_en_next   = strap_cfg_pkg::OUT_ENABLE_RESET;
            slew_next     = strap_cfg_pkg::SLEW_RESET;
            gpo_next      = strap_cfg_pkg::GPIO_OUT_RESET;
            gpoe_next     = strap_cfg_pkg::GPIO_OE_RESET;
        end else if (wr_en) begin
            case (wr_addr)
                strap_cfg_pkg::REF_TYPE_ADDR:   ref_type_next = wr_data;
                strap_cfg_pkg::OUT_ENABLE_ADDR: out_en_next   = wr_data;
                strap_cfg_pkg::SLEW_ADDR:       slew_next     = wr_data;
                strap_cfg_pkg::GPIO_OUT_ADDR:   gpo_next      = wr_data;
                strap_cfg_pkg::GPIO_OE_ADDR:    gpoe_next     = wr_data;
                default:                        ref_type_next = ref_type_reg;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref_type_reg <= strap_cfg_pkg::REF_TYPE_RESET;
            out_en_reg   <= strap_cfg_pkg::OUT_ENABLE_RESET;
            slew_reg     <= strap_cfg_pkg::SLEW_RESET;
            gpo_reg      <= strap_cfg_pkg::GPIO_OUT_RESET;
            gpoe_reg     <= strap_cfg_pkg::GPIO_OE_RESET;
        end else begin
            ref_type_reg <= ref_type_next;
            out_en_reg   <= out_en_next;
            slew_reg     <= slew_next;
            gpo_reg      <= gpo_next;
            gpoe_reg     <= gpoe_next;
        end
    end
    // Read answers and pin-facing outputs
    always_comb begin
        rvalid_next = host_acc && host_rd_i;
        rdata_next  = rdata_reg;
        if (host_acc && host_rd_i) begin
            case (host_addr_i)
                strap_cfg_pkg::STATUS_ADDR:  rdata_next = {2'(state_reg), 2'(mclk_freq_reg), 2'h0, mclk_sel_reg};
                strap_cfg_pkg::GPIO_IN_ADDR: rdata_next = {2'h0, gpio_sync};
                default:                     rdata_next = mem_rdata;
            endcase
        end
        clk_en_next   = 8'h00;
        gpio_out_next = gpo_reg[5:0];
        gpio_oe_next  = 6'h00;
        if (state_reg == strap_cfg_pkg::ST_STRAP || state_reg == strap_cfg_pkg::ST_RUN) begin
            clk_en_next    = out_en_reg;
            clk_en_next[0] = out_en_reg[0] | test_strap_reg;
        end
        // Strap pins stay inputs until the window closes
        if (state_reg == strap_cfg_pkg::ST_RUN) begin
            gpio_oe_next = gpoe_reg[5:0];
        end
    end
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 8'h00;
            clk_en_reg   <= 8'h00;
            gpio_out_reg <= 6'h00;
            gpio_oe_reg  <= 6'h00;
        end else begin
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            clk_en_reg   <= clk_en_next;
            gpio_out_reg <= gpio_out_next;
            gpio_oe_reg  <= gpio_oe_next;
        end
    end

    assign host_ready_o     = host_acc;
    assign host_rvalid_o    = rvalid_reg;
    assign host_rdata_o     = rdata_reg;
    assign otp_rd_o         = (state_reg == strap_cfg_pkg::ST_LOAD);
    assign otp_addr_o       = cnt_reg;
    assign gpio_o           = gpio_out_reg;
    assign gpio_oe_o        = gpio_oe_reg;
    assign mclk_freq_o      = mclk_freq_reg;
    assign strap_cfg_o      = strap_reg;
    assign clk_out_enable_o = clk_en_reg;
    assign ref_diff_o       = ref_type_reg[3:0];
    assign se_slew_fast_o   = slew_reg;
    assign cfg_running_o    = (state_reg == strap_cfg_pkg::ST_RUN);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_HOLD_IGNORES_HOST: assert property (
        (state_reg == strap_cfg_pkg::ST_HOLD) |-> !host_ready_o && wr_en && wr_addr == cnt_reg
            && wr_data == strap_cfg_pkg::cfg_default(cnt_reg))
        else $error("host access taken while held in reset");
    AST_OUTS_OFF_IN_HOLD: assert property (
        (state_reg == strap_cfg_pkg::ST_HOLD)[*2] |-> clk_out_enable_o == 8'h00)
        else $error("clock output enabled during reset");
    AST_MCLK_CAPTURE: assert property (
        capture |=> mclk_sel_reg == $past(gpio_sync[1:0]))
        else $error("clock select not taken at release");
    AST_MCLK_20M: assert property (
        capture && gpio_sync[1:0] == strap_cfg_pkg::MCLK_SEL_20M |=> mclk_freq_o == strap_cfg_pkg::MCLK_20M)
        else $error("select 10 not decoded as 20 MHz");
    AST_PINS_INPUT_IN_WINDOW: assert property (
        (gpio_oe_o != 6'h00) |-> $past(state_reg) == strap_cfg_pkg::ST_RUN)
        else $error("gpio driven inside the strap window");
    AST_WINDOW_END: assert property (
        state_reg == strap_cfg_pkg::ST_STRAP && win_reg == WIN_LAST && rst_n_sync
        |=> state_reg == strap_cfg_pkg::ST_RUN)
        else $error("window end not followed by run");
    AST_TEST_STRAP: assert property (
        test_strap_reg && state_reg == strap_cfg_pkg::ST_RUN |=> clk_out_enable_o[0])
        else $error("test strap did not enable first differential output");
    AST_REF_DEFAULT: assert property (
        state_reg == strap_cfg_pkg::ST_HOLD |=> ref_type_reg == strap_cfg_pkg::REF_TYPE_RESET)
        else $error("reference type not at default");
    AST_HOST_WRITE_APPLIED: assert property (
        host_wr_ok && host_addr_i == strap_cfg_pkg::REF_TYPE_ADDR |=> ref_diff_o == $past(host_wdata_i[3:0]))
        else $error("host write to reference type not applied");
    AST_OTP_BYTE_WRITTEN: assert property (
        otp_rd_o && rst_n_sync |=> wr_en && wr_addr == $past(otp_addr_o) && wr_data == otp_data_i)
        else $error("image byte not written to its address");

    COV_RUN: cover property (state_reg == strap_cfg_pkg::ST_STRAP ##1 state_reg == strap_cfg_pkg::ST_RUN);
    COV_OTP_DONE: cover property (otp_rd_o && otp_addr_o == strap_cfg_pkg::CFG_LAST);
    COV_HOST_WRITE: cover property (host_wr_ok && state_reg == strap_cfg_pkg::ST_RUN);
    COV_MCLK_24M: cover property (capture && gpio_sync[1:0] == strap_cfg_pkg::MCLK_SEL_24M576);
endmodule
`default_nettype wire

// ==== core/strap_cfg_pkg.sv ====
`default_nettype none
package strap_cfg_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned STRAP_WINDOW_MS  = 55;
    // Round down so the pins are handed back no later than the window's end
    localparam int unsigned STRAP_WINDOW_CYC_DEF = (STRAP_WINDOW_MS * 1000000) / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned CFG_DEPTH = 253;
    localparam int unsigned GPIO_W    = 6;
    localparam logic [7:0]  CFG_LAST  = 8'hfc;

    localparam logic [7:0] REF_TYPE_ADDR   = 8'h0a;
    localparam logic [7:0] OUT_ENABLE_ADDR = 8'h20;
    localparam logic [7:0] SLEW_ADDR       = 8'h21;
    localparam logic [7:0] GPIO_OUT_ADDR   = 8'h22;
    localparam logic [7:0] GPIO_OE_ADDR    = 8'h23;
    localparam logic [7:0] STATUS_ADDR     = 8'hfd;
    localparam logic [7:0] GPIO_IN_ADDR    = 8'hfe;

    localparam logic [7:0] REF_TYPE_RESET   = 8'h01;
    localparam logic [7:0] OUT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] SLEW_RESET       = 8'hff;
    localparam logic [7:0] GPIO_OUT_RESET   = 8'h00;
    localparam logic [7:0] GPIO_OE_RESET    = 8'h00;

    localparam logic [5:0] STRAP_MASK      = 6'h3b;
    localparam int unsigned TEST_STRAP_BIT = 2;
    localparam int unsigned REF_TYPES      = 4;
    localparam int unsigned DIFF_OUTS      = 8;
    localparam int unsigned SE_OUTS        = 8;

    localparam logic [1:0] MCLK_SEL_20M    = 2'h2;
    localparam logic [1:0] MCLK_SEL_24M576 = 2'h3;

    typedef enum logic [1:0] {MCLK_RESERVED, MCLK_20M, MCLK_24M576} mclk_e;
    typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_STRAP, ST_RUN} ldr_state_e;

    function automatic logic [7:0] cfg_default(input logic [7:0] addr);
        case (addr)
            REF_TYPE_ADDR:   cfg_default = REF_TYPE_RESET;
            OUT_ENABLE_ADDR: cfg_default = OUT_ENABLE_RESET;
            SLEW_ADDR:       cfg_default = SLEW_RESET;
            GPIO_OUT_ADDR:   cfg_default = GPIO_OUT_RESET;
            GPIO_OE_ADDR:    cfg_default = GPIO_OE_RESET;
            default:         cfg_default = 8'h00;
        endcase
    endfunction

    function automatic mclk_e mclk_decode(input logic [1:0] sel);
        case (sel)
            MCLK_SEL_20M:    mclk_decode = MCLK_20M;
            MCLK_SEL_24M576: mclk_decode = MCLK_24M576;
            default:         mclk_decode = MCLK_RESERVED;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== core/dual_ff_sync.sv ====
`default_nettype none
module dual_ff_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Reset to zero so a low-active pin reads as asserted until it is seen high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ==== core/cfg_space_mem.sv ====
`default_nettype none
module cfg_space_mem (
    input  wire logic       clk_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic [7:0] rd_addr_i,
    output logic      [7:0] rd_data_o
);
    // No reset: the loader sweeps defaults into every byte before release
    logic [7:0] mem [strap_cfg_pkg::CFG_DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i && (32'(wr_addr_i) < strap_cfg_pkg::CFG_DEPTH)) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = (32'(rd_addr_i) < strap_cfg_pkg::CFG_DEPTH) ? mem[rd_addr_i] : 8'h00;
endmodule
`default_nettype wire

// ==== verif/strap_board_model.sv ====
`default_nettype none
module strap_board_model (
    input  wire logic       ref_clk_i,
    input  wire logic [5:0] strap_i,
    input  wire logic [5:0] gpio_out_i,
    input  wire logic [5:0] gpio_oe_i,
    input  wire logic       otp_rd_i,
    input  wire logic [7:0] otp_addr_i,
    output logic      [5:0] gpio_pin_o,
    output logic      [7:0] otp_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Straps are resistor pulls: they hold through the window and win wherever the chip does not drive
    assign gpio_pin_o = (gpio_oe_i & gpio_out_i) | (~gpio_oe_i & strap_i);
    // Image byte is the address with bit 6 flipped; between reads the bus keeps changing
    always_ff @(posedge ref_clk_i) begin
        otp_data_o <= otp_rd_i ? (otp_addr_i ^ 8'h40) : (otp_data_o + 8'h37);
    end
endmodule
`default_nettype wire

// ==== verif/strap_config_loader_test.sv ====
`default_nettype none
module strap_config_loader_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WIN = 400;
    // Reset pin low time is cut from 2 ms to keep the run short
    localparam int unsigned RST_LOW = 300;
    logic       ref_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       chip_rst_n_i = 1'b0;
    logic [5:0] strap = 6'h00;
    logic       otp_programmed_i = 1'b0;
    logic       host_wr_i = 1'b0;
    logic       host_rd_i = 1'b0;
    logic [7:0] host_addr_i = 8'h00;
    logic [7:0] host_wdata_i = 8'h00;
    logic [5:0] gpio_i, gpio_o, gpio_oe_o, strap_cfg_o;
    logic       otp_rd_o, host_ready_o, host_rvalid_o, cfg_running_o;
    logic [7:0] otp_addr_o, otp_data_i, host_rdata_o, clk_out_enable_o, se_slew_fast_o;
    logic [3:0] ref_diff_o;
    strap_cfg_pkg::mclk_e mclk_freq_o;
    strap_cfg_pkg::mclk_e exp_m [4] = '{strap_cfg_pkg::MCLK_20M, strap_cfg_pkg::MCLK_24M576,
                                        strap_cfg_pkg::MCLK_RESERVED, strap_cfg_pkg::MCLK_RESERVED};
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    strap_config_loader #(.STRAP_WINDOW_CYC(WIN)) strap_config_loader_i (
        .ref_clk_i, .sys_rst_i, .chip_rst_n_i, .gpio_i, .gpio_o, .gpio_oe_o, .otp_programmed_i,
        .otp_rd_o, .otp_addr_o, .otp_data_i, .host_wr_i, .host_rd_i, .host_addr_i, .host_wdata_i,
        .host_ready_o, .host_rvalid_o, .host_rdata_o, .mclk_freq_o, .strap_cfg_o, .clk_out_enable_o,
        .ref_diff_o, .se_slew_fast_o, .cfg_running_o);
    strap_board_model strap_board_model_i (
        .ref_clk_i, .strap_i(strap), .gpio_out_i(gpio_o), .gpio_oe_i(gpio_oe_o), .otp_rd_i(otp_rd_o),
        .otp_addr_i(otp_addr_o), .gpio_pin_o(gpio_i), .otp_data_o(otp_data_i));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Request is held until an edge that sees ready high; the answer is read just after that edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        #1;
        host_wr_i = wr;
        host_rd_i = !wr;
        host_addr_i = a;
        host_wdata_i = d;
        @(negedge ref_clk_i);
        while (host_ready_o !== 1'b1 && n < 3000) begin
            @(negedge ref_clk_i);
            n++;
        end
        cmp8({7'h0, host_ready_o}, 8'h01, "ready");
        @(posedge ref_clk_i);
        #1;
        host_wr_i = 1'b0;
        host_rd_i = 1'b0;
        if (!wr) cmp8({7'h0, host_rvalid_o}, 8'h01, "read answer");
        q = host_rdata_o;
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        cmp8(q, exp, what);
    endtask
    task automatic power_up(input logic [5:0] s, input logic otp);
        @(posedge ref_clk_i);
        #1;
        chip_rst_n_i = 1'b0;
        strap = s;
        otp_programmed_i = otp;
        repeat (RST_LOW) @(posedge ref_clk_i);
        #1;
        chip_rst_n_i = 1'b1;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1;
        host_wr_i = 1'b1;
        host_addr_i = strap_cfg_pkg::REF_TYPE_ADDR;
        host_wdata_i = 8'h0e;
        @(posedge ref_clk_i);
        #1;
        host_wr_i = 1'b0;
        cmp8({7'h0, host_ready_o}, 8'h00, "ready in reset");
        cmp8(clk_out_enable_o, 8'h00, "enables in reset");
        cmp8({4'h0, ref_diff_o}, 8'h01, "ref type in reset");
        cmp8(se_slew_fast_o, 8'hff, "slew in reset");
        $display("test reset done");
        power_up(6'h3b, 1'b0);
        rd8(strap_cfg_pkg::REF_TYPE_ADDR, 8'h01, "ref default");
        cmp8({6'h0, mclk_freq_o}, {6'h0, strap_cfg_pkg::MCLK_24M576}, "clock select");
        cmp8({2'h0, strap_cfg_o}, 8'h3b, "straps");
        cmp8(clk_out_enable_o, 8'h00, "enables off");
        cmp8({2'h0, gpio_oe_o}, 8'h00, "gpio held in window");
        wr8(strap_cfg_pkg::REF_TYPE_ADDR, 8'h0e);
        wr8(strap_cfg_pkg::SLEW_ADDR, 8'h5a);
        wr8(strap_cfg_pkg::OUT_ENABLE_ADDR, 8'h81);
        wr8(8'hfc, 8'ha5);
        wr8(8'hff, 8'h77);
        cmp8({4'h0, ref_diff_o}, 8'h0e, "ref type write");
        cmp8(se_slew_fast_o, 8'h5a, "slew write");
        cmp8(clk_out_enable_o, 8'h81, "enable write");
        rd8(8'hfc, 8'ha5, "last byte");
        rd8(8'hff, 8'h00, "beyond space");
        while (cfg_running_o !== 1'b1 && cycles < 19000) @(negedge ref_clk_i);
        cmp8({7'h0, cfg_running_o}, 8'h01, "run entered");
        wr8(strap_cfg_pkg::GPIO_OUT_ADDR, 8'h15);
        wr8(strap_cfg_pkg::GPIO_OE_ADDR, 8'h3f);
        repeat (4) @(posedge ref_clk_i);
        cmp8({2'h0, gpio_oe_o}, 8'h3f, "gpio drive");
        rd8(strap_cfg_pkg::GPIO_IN_ADDR, 8'h15, "gpio readback");
        rd8(strap_cfg_pkg::STATUS_ADDR, {2'(strap_cfg_pkg::ST_RUN), 2'(strap_cfg_pkg::MCLK_24M576), 2'h0, 2'h3},
            "status");
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            power_up({3'h5, i[0], 2'(i + 2)}, i == 3);
            rd8(i == 3 ? 8'h05 : strap_cfg_pkg::REF_TYPE_ADDR, i == 3 ? 8'h45 : 8'h01, "loaded");
            repeat (2) @(posedge ref_clk_i);
            #1;
            cmp8({6'h0, mclk_freq_o}, {6'h0, exp_m[i]}, "clock select");
            cmp8({7'h0, clk_out_enable_o[0]}, {7'h0, strap[2]}, "test strap");
            cmp8({2'h0, strap_cfg_o}, {2'h0, strap & 6'h3b}, "captured straps");
        end
        $display("test strap table done");
        print_verdict();
    end
endmodule
`default_nettype wire
